// [design/lptc_frame_hold.sv]
// frame counter that freezes the modulation pattern for one frame
`timescale 1ns/10ps
module lptc_frame_hold #(
    parameter int unsigned FRAMES = lptc_pkg::EL_FRAMES
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_enable,
    input wire logic i_frame_pulse,
    output logic o_hold
);
    logic [lptc_pkg::EL_CNT_W-1:0] count_r;
    logic hold_r;
    wire at_end = (count_r == lptc_pkg::EL_CNT_W'(FRAMES - 1));

    // counts frames; after FRAMES frames the next frame is held
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            count_r <= '0;
            hold_r <= 1'b0;
        end
        else if (!i_enable)
        begin
            count_r <= '0;
            hold_r <= 1'b0;
        end
        else if (i_frame_pulse)
        begin
            hold_r <= at_end;
            // held frame not counted, so FRAMES plain frames lie between holds
            count_r <= (at_end || hold_r) ? '0 : count_r + 1'b1;
        end
    end

    assign o_hold = hold_r;

    a_hold_needs_enable: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_hold |-> $past(i_enable))
        else $error("hold seen while electroluminescent support disabled");
endmodule : lptc_frame_hold

// [design/lptc_pkg.sv]
// constants for the panel configuration and horizontal timing block
package lptc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] OFF_PANEL_TYPE = 8'h30;
    localparam logic [7:0] OFF_AC_BIAS = 8'h31;
    localparam logic [7:0] OFF_HDISP = 8'h32;
    localparam logic [7:0] OFF_HBLANK = 8'h34;
    localparam logic [7:0] OFF_LP_START = 8'h35;
    localparam logic [7:0] OFF_LP_WIDTH = 8'h36;
    localparam logic [7:0] OFF_CTRL = 8'h3e;
    localparam logic [7:0] OFF_STATUS = 8'h3f;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] MASK_PANEL_TYPE = 8'hbf;
    localparam logic [7:0] MASK_AC_BIAS = 8'h3f;
    localparam logic [7:0] MASK_HDISP = 8'h7f;
    localparam logic [7:0] MASK_HBLANK = 8'h1f;
    localparam logic [7:0] MASK_LP_START = 8'h1f;
    localparam logic [7:0] MASK_LP_WIDTH = 8'h8f;
    localparam logic [7:0] MASK_CTRL = 8'h01;
    localparam int BIT_EL_EN = 7;
    localparam int BIT_FORMAT = 3;
    localparam int BIT_COLOUR = 2;
    localparam int BIT_DUAL = 1;
    localparam int BIT_ACTIVE = 0;
    localparam int BIT_LP_POL = 7;
    localparam int BIT_BPP_HI = 0;
    localparam logic [1:0] WIDTH_NARROW = 2'h0;
    localparam logic [1:0] WIDTH_MID = 2'h1;
    localparam logic [1:0] WIDTH_WIDE = 2'h2;
    localparam logic [1:0] WIDTH_RSVD = 2'h3;
    localparam int PIX_PER_UNIT = 8;
    localparam logic [2:0] PIX_UNIT_MAX = 3'h7;
    localparam logic [2:0] LP_FINE_LOW_BPP = 3'h4;
    localparam logic [2:0] LP_FINE_HIGH_BPP = 3'h6;
    localparam int EL_FRAMES = 262143;
    localparam int EL_CNT_W = 18;
    typedef enum logic [1:0] {LPTC_ACTIVE, LPTC_BLANK} lptc_phase_e;
endpackage : lptc_pkg

// [design/lptc_timing.sv]
// panel configuration registers and horizontal line timing
// What this block does
// - with electroluminescent support set, modulation freezes one frame after every 262143 frames
// - two-bit width field picks data bus width; code 11 reserved
// - format bit picks second 8-bit single colour passive arrangement
// - colour bit set means colour panel, clear means monochrome
// - scan bit set means dual scan, clear means single scan
// - technology bit set means active matrix, clear means passive
// - passive, nonzero rate: ac-bias toggles after that many line pulses
// - rate zero: ac-bias toggles on every frame pulse
// - active width in pixels is (value plus one) times eight
// - non-display period is (value plus one) times eight pixels
// - active panels delay line pulse from blank start by start value
// - start delay is value times eight plus 4 or plus 6 pixels
// - polarity bit set: active high on active, low on passive; clear inverts
// - active line-pulse width is (value plus one) times eight pixels
`timescale 1ns/10ps
module lptc_timing #(
    parameter int unsigned EL_FRAMES = lptc_pkg::EL_FRAMES
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    input wire logic i_frame_pulse,
    output logic [7:0] o_rdata,
    output logic o_line_pulse,
    output logic o_ac_bias_toggle,
    output logic o_display_active,
    output logic o_frm_hold,
    output logic [4:0] o_bus_width,
    output logic o_colour,
    output logic o_dual_scan,
    output logic o_active_panel,
    output logic o_format2
);
    logic rst_s1_r;
    logic rst_n_r;
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    // frame pulse is an external pin
    logic fp_s1_r;
    logic fp_s2_r;
    logic fp_d_r;
    always_ff @(posedge i_clock or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            fp_s1_r <= 1'b0;
            fp_s2_r <= 1'b0;
            fp_d_r <= 1'b0;
        end
        else
        begin
            fp_s1_r <= i_frame_pulse;
            fp_s2_r <= fp_s1_r;
            fp_d_r <= fp_s2_r;
        end
    end
    wire frame_evt = fp_s2_r && !fp_d_r;

    logic [7:0] panel_type_r;
    logic [7:0] ac_bias_rate_r;
    logic [7:0] hdisp_r;
    logic [7:0] hblank_r;
    logic [7:0] lp_start_r;
    logic [7:0] lp_width_r;
    logic [7:0] ctrl_r;

    wire wr_panel = i_write && (i_addr == lptc_pkg::OFF_PANEL_TYPE);
    wire wr_bias = i_write && (i_addr == lptc_pkg::OFF_AC_BIAS);
    wire wr_hdisp = i_write && (i_addr == lptc_pkg::OFF_HDISP);
    wire wr_hblank = i_write && (i_addr == lptc_pkg::OFF_HBLANK);
    wire wr_start = i_write && (i_addr == lptc_pkg::OFF_LP_START);
    wire wr_width = i_write && (i_addr == lptc_pkg::OFF_LP_WIDTH);
    wire wr_ctrl = i_write && (i_addr == lptc_pkg::OFF_CTRL);

    always_ff @(posedge i_clock or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            panel_type_r <= lptc_pkg::RST_BYTE;
            ac_bias_rate_r <= lptc_pkg::RST_BYTE;
            hdisp_r <= lptc_pkg::RST_BYTE;
            hblank_r <= lptc_pkg::RST_BYTE;
            lp_start_r <= lptc_pkg::RST_BYTE;
            lp_width_r <= lptc_pkg::RST_BYTE;
            ctrl_r <= lptc_pkg::RST_BYTE;
        end
        else
        begin
            if (wr_panel) panel_type_r <= i_wdata & lptc_pkg::MASK_PANEL_TYPE;
            if (wr_bias) ac_bias_rate_r <= i_wdata & lptc_pkg::MASK_AC_BIAS;
            if (wr_hdisp) hdisp_r <= i_wdata & lptc_pkg::MASK_HDISP;
            if (wr_hblank) hblank_r <= i_wdata & lptc_pkg::MASK_HBLANK;
            if (wr_start) lp_start_r <= i_wdata & lptc_pkg::MASK_LP_START;
            if (wr_width) lp_width_r <= i_wdata & lptc_pkg::MASK_LP_WIDTH;
            if (wr_ctrl) ctrl_r <= i_wdata & lptc_pkg::MASK_CTRL;
        end
    end

    wire el_en = panel_type_r[lptc_pkg::BIT_EL_EN];
    wire active_panel = panel_type_r[lptc_pkg::BIT_ACTIVE];
    wire dual_scan = panel_type_r[lptc_pkg::BIT_DUAL];
    wire colour = panel_type_r[lptc_pkg::BIT_COLOUR];
    wire [1:0] width_code = panel_type_r[5:4];
    wire lp_pol = lp_width_r[lptc_pkg::BIT_LP_POL];
    wire bpp_high = ctrl_r[lptc_pkg::BIT_BPP_HI];

    // only an 8-bit single colour passive panel honours the format bit
    wire format2 = panel_type_r[lptc_pkg::BIT_FORMAT] && colour && !dual_scan
        && !active_panel && (width_code == lptc_pkg::WIDTH_MID);

    // reserved code drives a zero width rather than guess a bus
    logic [4:0] bus_width;
    always_comb
    begin
        unique case (width_code)
            lptc_pkg::WIDTH_NARROW: bus_width = active_panel ? 5'h09 : 5'h04;
            lptc_pkg::WIDTH_MID: bus_width = active_panel ? 5'h0c : 5'h08;
            lptc_pkg::WIDTH_WIDE: bus_width = active_panel ? 5'h12 : 5'h10;
            lptc_pkg::WIDTH_RSVD: bus_width = 5'h00;
        endcase
    end

    // horizontal counter: sub counts pixels in a unit, unit counts 8-pixel units
    lptc_pkg::lptc_phase_e phase_r;
    logic [2:0] sub_r;
    logic [6:0] unit_r;
    wire unit_end = (sub_r == lptc_pkg::PIX_UNIT_MAX);
    wire disp_end = unit_end && (phase_r == lptc_pkg::LPTC_ACTIVE)
        && (unit_r == hdisp_r[6:0]);
    wire blank_end = unit_end && (phase_r == lptc_pkg::LPTC_BLANK)
        && (unit_r == {2'h0, hblank_r[4:0]});

    always_ff @(posedge i_clock or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            phase_r <= lptc_pkg::LPTC_ACTIVE;
            sub_r <= 3'h0;
            unit_r <= 7'h00;
        end
        else
        begin
            sub_r <= sub_r + 3'h1;
            if (disp_end)
            begin
                phase_r <= lptc_pkg::LPTC_BLANK;
                unit_r <= 7'h00;
            end
            else if (blank_end)
            begin
                phase_r <= lptc_pkg::LPTC_ACTIVE;
                unit_r <= 7'h00;
            end
            else if (unit_end)
                unit_r <= unit_r + 7'h01;
        end
    end

    // pixel position inside the blank period
    wire in_blank = (phase_r == lptc_pkg::LPTC_BLANK);
    wire [9:0] blank_pix = {unit_r, sub_r};
    wire [2:0] fine = bpp_high ? lptc_pkg::LP_FINE_HIGH_BPP : lptc_pkg::LP_FINE_LOW_BPP;
    wire [9:0] lp_begin = {2'h0, lp_start_r[4:0], fine};
    wire [9:0] lp_len = {3'h0, lp_width_r[3:0] + 4'h0, 3'h0} + 10'(lptc_pkg::PIX_PER_UNIT);
    // active panels: windowed pulse; passive: one unit at blank start
    wire lp_active_win = in_blank && (blank_pix >= lp_begin)
        && (blank_pix < lp_begin + lp_len);
    wire lp_passive_win = in_blank && (unit_r == 7'h00);
    wire lp_assert = active_panel ? lp_active_win : lp_passive_win;
    // set bit: high on active, low on passive; clear inverts both
    wire lp_level = lp_assert ^ (lp_pol ^ active_panel);
    wire line_evt = disp_end;

    // ac-bias toggle timing
    logic [5:0] bias_cnt_r;
    logic bias_r;
    wire bias_zero = (ac_bias_rate_r[5:0] == 6'h00);
    wire bias_hit = line_evt && (bias_cnt_r + 6'h01 >= ac_bias_rate_r[5:0]);
    wire bias_toggle = bias_zero ? frame_evt : (!active_panel && bias_hit);

    always_ff @(posedge i_clock or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            bias_cnt_r <= 6'h00;
            bias_r <= 1'b0;
        end
        else
        begin
            if (bias_zero || bias_hit)
                bias_cnt_r <= 6'h00;
            else if (line_evt)
                bias_cnt_r <= bias_cnt_r + 6'h01;
            if (bias_toggle)
                bias_r <= ~bias_r;
        end
    end

    logic frm_hold;
    lptc_frame_hold #(
        .FRAMES(EL_FRAMES)
    ) u_hold (
        .i_clock(i_clock),
        .i_rst_n(rst_n_r),
        .i_enable(el_en),
        .i_frame_pulse(frame_evt),
        .o_hold(frm_hold)
    );

    // read mux; unmapped offsets answer zero
    logic [7:0] rd_mux;
    always_comb
    begin
        unique case (i_addr)
            lptc_pkg::OFF_PANEL_TYPE: rd_mux = panel_type_r;
            lptc_pkg::OFF_AC_BIAS: rd_mux = ac_bias_rate_r;
            lptc_pkg::OFF_HDISP: rd_mux = hdisp_r;
            lptc_pkg::OFF_HBLANK: rd_mux = hblank_r;
            lptc_pkg::OFF_LP_START: rd_mux = lp_start_r;
            lptc_pkg::OFF_LP_WIDTH: rd_mux = lp_width_r;
            lptc_pkg::OFF_CTRL: rd_mux = ctrl_r;
            lptc_pkg::OFF_STATUS: rd_mux = {5'h00, frm_hold, bias_r, in_blank};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge i_clock or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            o_rdata <= 8'h00;
            o_line_pulse <= 1'b0;
            o_ac_bias_toggle <= 1'b0;
            o_display_active <= 1'b0;
            o_frm_hold <= 1'b0;
            o_bus_width <= 5'h00;
            o_colour <= 1'b0;
            o_dual_scan <= 1'b0;
            o_active_panel <= 1'b0;
            o_format2 <= 1'b0;
        end
        else
        begin
            o_rdata <= i_read ? rd_mux : 8'h00;
            o_line_pulse <= lp_level;
            o_ac_bias_toggle <= bias_r;
            o_display_active <= !in_blank;
            o_frm_hold <= frm_hold;
            o_bus_width <= bus_width;
            o_colour <= colour;
            o_dual_scan <= dual_scan;
            o_active_panel <= active_panel;
            o_format2 <= format2;
        end
    end

    // clocks spent in the current phase, kept apart from the unit counter
    logic [9:0] phase_pix_r;
    always_ff @(posedge i_clock or negedge rst_n_r)
    begin
        if (!rst_n_r)
            phase_pix_r <= 10'h000;
        else if (disp_end || blank_end)
            phase_pix_r <= 10'h000;
        else
            phase_pix_r <= phase_pix_r + 10'h001;
    end

    a_lp_polarity: assert property (@(posedge i_clock) disable iff (!rst_n_r)
        !lp_assert |=> (o_line_pulse == ($past(lp_pol) ^ $past(active_panel))))
        else $error("idle line pulse level wrong");
    a_display_len: assert property (@(posedge i_clock) disable iff (!rst_n_r)
        disp_end |-> (phase_pix_r == {hdisp_r[6:0], 3'h7}))
        else $error("display period length wrong");
    a_blank_len: assert property (@(posedge i_clock) disable iff (!rst_n_r)
        blank_end |-> (phase_pix_r == {2'h0, hblank_r[4:0], 3'h7}))
        else $error("blank period length wrong");
    a_unit_step: assert property (@(posedge i_clock) disable iff (!rst_n_r)
        (unit_r != $past(unit_r)) |-> $past(sub_r) == lptc_pkg::PIX_UNIT_MAX)
        else $error("unit advanced mid unit");
    a_bias_frame: assert property (@(posedge i_clock) disable iff (!rst_n_r)
        (bias_zero && frame_evt) |=> bias_r != $past(bias_r))
        else $error("no toggle on frame with rate zero");
    a_bias_lines: assert property (@(posedge i_clock) disable iff (!rst_n_r)
        (!bias_zero && !line_evt && !frame_evt) |=> bias_r == $past(bias_r))
        else $error("ac-bias toggled without a line pulse");
    // a window moved by a register write mid-blank may open anywhere
    a_lp_start: assert property (@(posedge i_clock) disable iff (!rst_n_r)
        (active_panel && lp_active_win && !$past(lp_active_win) && $past(in_blank)
            && $stable(lp_begin) && $stable(lp_len)) |-> blank_pix == lp_begin)
        else $error("line pulse started off position");
    a_bus_width: assert property (@(posedge i_clock) disable iff (!rst_n_r)
        (width_code == lptc_pkg::WIDTH_RSVD) |=> o_bus_width == 5'h00)
        else $error("reserved width code not zero");
    a_format_gate: assert property (@(posedge i_clock) disable iff (!rst_n_r)
        active_panel |=> !o_format2)
        else $error("format2 on an active panel");

    c_line_done: cover property (@(posedge i_clock) disable iff (!rst_n_r) blank_end);
    c_bias_line: cover property (@(posedge i_clock) disable iff (!rst_n_r)
        bias_toggle && !bias_zero);
    c_bias_frame: cover property (@(posedge i_clock) disable iff (!rst_n_r)
        bias_toggle && bias_zero);
    c_active_lp: cover property (@(posedge i_clock) disable iff (!rst_n_r)
        active_panel && lp_active_win);
endmodule : lptc_timing

// [tb/lptc_panel_model.sv]
// panel-side model: measures line timing and sends frame pulses
`timescale 1ns/10ps
module lptc_panel_model (
    input wire logic i_clock,
    input wire logic i_line_pulse,
    input wire logic i_display_active,
    input wire logic i_ac_bias_toggle,
    input wire logic i_frame_req,
    output logic o_frame_pulse,
    output logic [15:0] o_disp_len,
    output logic [15:0] o_blank_len,
    output logic [15:0] o_lp_delay,
    output logic [15:0] o_lp_len,
    output logic [15:0] o_lines,
    output logic [15:0] o_flips
);
    logic disp_q = 1'b0;
    logic lp_q = 1'b0;
    logic bias_q = 1'b0;
    logic lp_seen = 1'b0;
    logic [2:0] fcnt = 3'h0;
    logic [15:0] run = 16'h0000;
    logic [15:0] lp_run = 16'h0000;
    logic [15:0] since = 16'h0000;
    wire fall = disp_q && !i_display_active;
    wire [15:0] gap = fall ? 16'h0000 : since;
    // frame pulse held several clocks so the two-flop sync cannot miss it
    assign o_frame_pulse = (fcnt != 3'h0);
    initial
    begin
        {o_disp_len, o_blank_len, o_lp_delay} = '0;
        {o_lp_len, o_lines, o_flips} = '0;
    end
    always @(posedge i_clock)
    begin
        disp_q <= i_display_active;
        lp_q <= i_line_pulse;
        bias_q <= i_ac_bias_toggle;
        if (i_frame_req)
            fcnt <= 3'h4;
        else if (fcnt != 3'h0)
            fcnt <= fcnt - 3'h1;
        run <= (i_display_active != disp_q) ? 16'h0001 : run + 16'h0001;
        since <= fall ? 16'h0001 : since + 16'h0001;
        lp_run <= (i_line_pulse != lp_q) ? 16'h0001 : lp_run + 16'h0001;
        if (i_ac_bias_toggle != bias_q)
            o_flips <= o_flips + 16'h0001;
        if (fall)
        begin
            o_disp_len <= run;
            o_lines <= o_lines + 16'h0001;
            lp_seen <= 1'b0;
        end
        if (!disp_q && i_display_active)
            o_blank_len <= run;
        // polarity-agnostic: first edge in blank is leading, second trailing
        if (i_line_pulse != lp_q)
        begin
            if (!lp_seen || fall)
            begin
                o_lp_delay <= gap;
                lp_seen <= 1'b1;
            end
            else
                o_lp_len <= lp_run;
        end
    end
endmodule : lptc_panel_model

// [tb/testbench.sv]
// self-checking bench for the panel timing block
`timescale 1ns/10ps
module testbench;
    logic i_clock = 1'b0;
    logic i_reset_n = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_write = 1'b0;
    logic i_read = 1'b0;
    logic frame_req = 1'b0;
    int error_cnt = 0;
    int tests_run = 0;
    wire fp, lp, bias, dact, hold, colour, dual, act, fmt2;
    wire [7:0] rdata;
    wire [4:0] bw;
    wire [15:0] dlen, blen, lpd, lpl, lines, flips;
    logic [7:0] offs [7] = '{8'h30, 8'h31, 8'h32, 8'h34, 8'h35, 8'h36, 8'h3e};
    logic [7:0] msks [7] = '{8'hbf, 8'h3f, 8'h7f, 8'h1f, 8'h1f, 8'h8f, 8'h01};
    logic [4:0] wtab [8] = '{5'd4, 5'd8, 5'd16, 5'd0, 5'd9, 5'd12, 5'd18, 5'd0};
    always #50 i_clock = ~i_clock;
    lptc_timing #(.EL_FRAMES(4)) lptc_timing_inst (.i_clock(i_clock), .i_reset_n(i_reset_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
        .i_frame_pulse(fp), .o_rdata(rdata), .o_line_pulse(lp), .o_ac_bias_toggle(bias),
        .o_display_active(dact), .o_frm_hold(hold), .o_bus_width(bw), .o_colour(colour),
        .o_dual_scan(dual), .o_active_panel(act), .o_format2(fmt2));
    lptc_panel_model lptc_panel_model_inst (.i_clock(i_clock), .i_line_pulse(lp),
        .i_display_active(dact), .i_ac_bias_toggle(bias), .i_frame_req(frame_req),
        .o_frame_pulse(fp), .o_disp_len(dlen), .o_blank_len(blen), .o_lp_delay(lpd),
        .o_lp_len(lpl), .o_lines(lines), .o_flips(flips));
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : cyc
    task automatic rst();
        @(posedge i_clock);
        i_reset_n <= 1'b0;
        cyc(5);
        @(posedge i_clock);
        i_reset_n <= 1'b1;
        cyc(3);
    endtask : rst
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_wdata <= d;
        i_write <= 1'b1;
        @(posedge i_clock);
        i_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_read <= 1'b1;
        @(posedge i_clock);
        i_read <= 1'b0;
        #1;
        d = rdata;
    endtask : rd
    task automatic wait_lines(input int n);
        logic [15:0] s;
        int k;
        s = lines;
        k = 0;
        while (lines < s + 16'(n) && k < 3000)
        begin
            @(posedge i_clock);
            k++;
        end
        chk_bit(k < 3000, 1'b1);
        cyc(4);
    endtask : wait_lines
    task automatic frames(input int n);
        repeat (n)
        begin
            @(posedge i_clock);
            frame_req <= 1'b1;
            @(posedge i_clock);
            frame_req <= 1'b0;
            cyc(12);
        end
    endtask : frames
    task automatic t_regs();
        logic [7:0] d;
        for (int i = 0; i < 7; i++)
        begin
            rd(offs[i], d);
            chk_val(d, 16'h0000);
            wr(offs[i], 8'hff);
            rd(offs[i], d);
            chk_val(d, msks[i]); // reserved bits read zero
        end
        wr(8'h33, 8'hff);
        rd(8'h33, d);
        chk_val(d, 16'h0000);
        $display("test regs done");
    endtask : t_regs
    task automatic t_type();
        for (int i = 0; i < 8; i++)
        begin
            wr(8'h30, {2'b00, 2'(i), 3'b000, i[2]});
            cyc(2);
            chk_val(bw, wtab[i]);
            chk_bit(act, i[2]);
        end
        wr(8'h30, 8'h1c);
        cyc(2);
        chk_bit(fmt2, 1'b1);
        chk_bit(colour, 1'b1);
        chk_bit(dual, 1'b0);
        wr(8'h30, 8'h12);
        cyc(2);
        chk_bit(fmt2, 1'b0);
        chk_bit(colour, 1'b0);
        chk_bit(dual, 1'b1);
        $display("test type done");
    endtask : t_type
    task automatic t_hpass();
        wr(8'h30, 8'h00);
        wr(8'h32, 8'h03);
        wr(8'h34, 8'h02);
        wr(8'h36, 8'h00);
        wait_lines(3);
        chk_val(dlen, 16'd32);
        chk_val(blen, 16'd24);
        chk_val(lpd, 16'd0);
        chk_val(lpl, 16'd8);
        $display("test passive line done");
    endtask : t_hpass
    task automatic t_hact();
        wr(8'h30, 8'h01);
        wr(8'h32, 8'h04);
        wr(8'h34, 8'h05);
        wr(8'h35, 8'h01);
        wr(8'h36, 8'h81);
        wr(8'h3e, 8'h00);
        wait_lines(3);
        chk_val(dlen, 16'd40);
        chk_val(blen, 16'd48);
        chk_val(lpd, 16'd12);
        chk_val(lpl, 16'd16);
        wr(8'h3e, 8'h01);
        wait_lines(3);
        chk_val(lpd, 16'd14);
        $display("test active line done");
    endtask : t_hact
    task automatic t_pol();
        int k;
        wr(8'h32, 8'h03);
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h30, {7'h00, i[0]});
            wr(8'h36, {i[1], 7'h01});
            wait_lines(2);
            k = 0;
            while (dact !== 1'b1 && k < 200)
            begin
                cyc(1);
                k++;
            end
            chk_bit(k < 200, 1'b1);
            chk_bit(lp, i[1] ^ i[0]);
        end
        $display("test polarity done");
    endtask : t_pol
    task automatic t_bias();
        logic [15:0] f0;
        wr(8'h30, 8'h00);
        wr(8'h36, 8'h00);
        wr(8'h31, 8'h02);
        wait_lines(2);
        f0 = flips;
        wait_lines(4);
        chk_val(flips - f0, 16'd2);
        wr(8'h31, 8'h00);
        cyc(4);
        f0 = flips;
        frames(3);
        chk_val(flips - f0, 16'd3);
        $display("test bias done");
    endtask : t_bias
    task automatic t_el();
        logic [7:0] d;
        rst();
        frames(5);
        chk_bit(hold, 1'b0);
        rst();
        wr(8'h30, 8'h80);
        frames(4);
        chk_bit(hold, 1'b1);
        frames(1);
        chk_bit(hold, 1'b0);
        frames(3);
        chk_bit(hold, 1'b0);
        frames(1);
        chk_bit(hold, 1'b1);
        rd(8'h3f, d);
        chk_bit(d[2], 1'b1);
        $display("test frame hold done");
    endtask : t_el
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude
    initial
    begin
        #5000000;
        error_cnt++;
        $display("[ERR] %0t watchdog expired", $time);
        conclude();
    end
    initial
    begin
        rst();
        t_regs();
        t_type();
        t_hpass();
        t_hact();
        t_pol();
        t_bias();
        t_el();
        conclude();
    end
endmodule : testbench
